// file: common/scw_cfg.svh
`ifndef SCW_CFG_SVH
`define SCW_CFG_SVH
// System clock rate in kHz
`define SCW_CLK_KHZ 125000
// Command codes of the two configuration cells
`define SCW_CMD_EMIS 8'h24
`define SCW_CMD_ADDR 8'h2e
// Cell reset values
`define SCW_EMIS_RST 16'hf850
`define SCW_ADDR_RST 16'h003a
// Lowest accepted emissivity code, 0.1 * 65536 - 1 rounded down
`define SCW_EMIS_MIN 16'h1998
// Address every target answers to
`define SCW_ADDR_GENERAL 7'h00
// PEC polynomial x^8+x^2+x+1 without the top bit
`define SCW_CRC_POLY 8'h07
// Frame byte positions
`define SCW_IDX_ADDR 3'h0
`define SCW_IDX_CMD 3'h1
`define SCW_IDX_LO 3'h2
`define SCW_IDX_HI 3'h3
`define SCW_IDX_PEC 3'h4
// SDA hold after SCL fall, least time, rounds up
`define SCW_SDA_HOLD_NS 300
`define SCW_SDA_HOLD_CYC ((`SCW_SDA_HOLD_NS * `SCW_CLK_KHZ + 999999) / 1000000)
// SCL low timeout, longest time, rounds down
`define SCW_LOW_TO_MS 27
`define SCW_LOW_TO_CYC (`SCW_LOW_TO_MS * `SCW_CLK_KHZ)
// SCL high timeout, longest time, rounds down
`define SCW_HIGH_TO_US 45
`define SCW_HIGH_TO_CYC (`SCW_HIGH_TO_US * `SCW_CLK_KHZ / 1000)
// Cell store time after erase or write
`define SCW_WRITE_MS 5
`define SCW_WRITE_CYC (`SCW_WRITE_MS * `SCW_CLK_KHZ)
`endif

// file: common/scw_pkg.sv
package scw_pkg;
   // Frame reception state
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RECV,
      ST_DONE,
      ST_IGNORE
   } scw_state_t;
   // Both configuration cells
   typedef struct packed {
      logic [15:0] emis;
      logic [15:0] addr;
   } scw_cells_t;
   // Received Write Word payload
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] lo;
      logic [7:0] hi;
   } scw_frame_t;
endpackage

// file: design/scw_target.sv
`include "scw_cfg.svh"
module scw_target #(
   parameter int unsigned LOW_TO_CYC = `SCW_LOW_TO_CYC,
   parameter int unsigned HIGH_TO_CYC = `SCW_HIGH_TO_CYC,
   parameter int unsigned WRITE_CYC = `SCW_WRITE_CYC
) (
   // Clock, reset, enable
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   // Two-wire link, SCL also clocks the sampling flop
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Nonvolatile cell store
   input scw_pkg::scw_cells_t nv_cells_in,
   output scw_pkg::scw_cells_t cells_out,
   output logic store_strobe_out,
   output logic busy_out,
   output logic [6:0] active_addr_out
);
   import scw_pkg::*;

   localparam int TO_W = $clog2(LOW_TO_CYC + 1);
   localparam int WR_W = $clog2(WRITE_CYC + 1);
   localparam logic [5:0] HOLD_CYC = 6'(`SCW_SDA_HOLD_CYC);

   // One CRC-8 step over a whole byte, top bit first
   function automatic logic [7:0] scw_crc8(input logic [7:0] crc,
                                           input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `SCW_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // Link domain: SDA caught on every SCL rise
   logic link_bit_reg;
   logic link_tgl_reg;

   always_ff @(posedge scl_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         link_bit_reg <= 1'b0;
         link_tgl_reg <= 1'b0;
      end else begin
         link_bit_reg <= sda_in;
         link_tgl_reg <= ~link_tgl_reg;
      end
   end

   // Synchronisers; third stage only for edge detection
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic [2:0] tgl_sync_reg;

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         tgl_sync_reg <= 3'h0;
      end else if (clk_en_in) begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
         tgl_sync_reg <= {tgl_sync_reg[1:0], link_tgl_reg};
      end
   end

   // Protocol state
   scw_state_t state_reg;
   scw_state_t state_next;
   logic [2:0] byte_idx_reg;
   logic [3:0] bit_cnt_reg;
   logic ack_slot_reg;
   logic [7:0] shift_reg;
   logic [7:0] crc_reg;
   scw_frame_t frame_reg;
   logic [5:0] hold_cnt_reg;
   logic hold_val_reg;
   logic sda_oe_reg;
   logic [TO_W-1:0] to_cnt_reg;
   logic [WR_W-1:0] busy_cnt_reg;
   scw_cells_t cells_reg;
   logic [6:0] active_addr_reg;
   logic loaded_reg;
   logic strobe_reg;

   // Bus conditions from the synchronised pins
   wire scl_hi = scl_sync_reg[1];
   wire scl_edge = scl_sync_reg[1] ^ scl_sync_reg[2];
   wire scl_fall = scl_sync_reg[2] & ~scl_sync_reg[1];
   wire scl_steady_hi = scl_sync_reg[1] & scl_sync_reg[2];
   wire start_det = scl_steady_hi & sda_sync_reg[2] & ~sda_sync_reg[1];
   wire stop_det = scl_steady_hi & ~sda_sync_reg[2] & sda_sync_reg[1];
   wire bit_evt = tgl_sync_reg[1] ^ tgl_sync_reg[2];
   wire in_frame = (state_reg != ST_IDLE);

   // Bit and byte boundaries
   wire byte_full = (bit_cnt_reg == 4'h8);
   wire take_bit = bit_evt & in_frame & ~ack_slot_reg & ~byte_full;
   wire byte_end = scl_fall & in_frame & ~ack_slot_reg & byte_full;
   wire ack_end = scl_fall & ack_slot_reg;

   // Timeouts; the limit follows the current SCL level
   wire [TO_W-1:0] to_lim = scl_hi ? TO_W'(HIGH_TO_CYC) : TO_W'(LOW_TO_CYC);
   wire to_hit = in_frame & (to_cnt_reg >= to_lim);
   wire comm_end = stop_det | to_hit;

   // Byte decisions taken at the eighth SCL fall
   wire addr_hit = (shift_reg[7:1] == active_addr_reg) |
                   (shift_reg[7:1] == `SCW_ADDR_GENERAL);
   wire addr_ok = addr_hit & ~shift_reg[0] & ~busy_out & loaded_reg;
   wire cmd_ok = (shift_reg == `SCW_CMD_EMIS) |
                 (shift_reg == `SCW_CMD_ADDR);
   wire pec_ok = (shift_reg == crc_reg);
   wire is_addr = (byte_idx_reg == `SCW_IDX_ADDR);
   wire is_cmd = (byte_idx_reg == `SCW_IDX_CMD);
   wire is_pec = (byte_idx_reg == `SCW_IDX_PEC);
   wire is_data = (byte_idx_reg == `SCW_IDX_LO) |
                  (byte_idx_reg == `SCW_IDX_HI);
   wire byte_ok = (is_addr & addr_ok) | (is_cmd & cmd_ok) | is_data |
                  (is_pec & pec_ok);
   wire ack_want = byte_ok & (state_reg == ST_RECV);
   wire [7:0] crc_next = is_pec ? crc_reg : scw_crc8(crc_reg, shift_reg);

   // Next frame state after a byte; a bad byte drops the rest
   always_comb begin
      state_next = state_reg;
      if (start_det) begin
         state_next = ST_RECV;
      end else if (comm_end) begin
         state_next = ST_IDLE;
      end else if (byte_end) begin
         if (!ack_want) begin
            state_next = ST_IGNORE;
         end else if (is_pec) begin
            state_next = ST_DONE;
         end
      end
   end

   // Commit decision at stop of a complete, checked frame
   wire [15:0] word = {frame_reg.hi, frame_reg.lo};
   wire erase = (word == 16'h0000);
   wire emis_ok = erase | (word >= `SCW_EMIS_MIN);
   wire addr_word_ok = erase | (frame_reg.hi == 8'h00);
   wire commit = stop_det & (state_reg == ST_DONE);
   wire wr_emis = commit & (frame_reg.cmd == `SCW_CMD_EMIS) & emis_ok;
   wire wr_addr = commit & (frame_reg.cmd == `SCW_CMD_ADDR) & addr_word_ok;

   // Frame state register
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= ST_IDLE;
      end else if (clk_en_in) begin
         state_reg <= state_next;
      end
   end

   // Bit counter and acknowledge slot; a start restarts both
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bit_cnt_reg <= 4'h0;
         ack_slot_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (start_det || comm_end || ack_end) begin
            bit_cnt_reg <= 4'h0;
            ack_slot_reg <= 1'b0;
         end else if (byte_end) begin
            ack_slot_reg <= 1'b1;
         end else if (take_bit) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
      end
   end

   // Shift in, first bit lands on top
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shift_reg <= 8'h00;
      end else if (clk_en_in && take_bit) begin
         shift_reg <= {shift_reg[6:0], link_bit_reg};
      end
   end

   // Byte index and running PEC
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         byte_idx_reg <= 3'h0;
         crc_reg <= 8'h00;
      end else if (clk_en_in) begin
         if (start_det) begin
            byte_idx_reg <= 3'h0;
            crc_reg <= 8'h00;
         end else if (byte_end && ack_want) begin
            byte_idx_reg <= byte_idx_reg + 3'h1;
            crc_reg <= crc_next;
         end
      end
   end

   // Payload capture
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         frame_reg <= '0;
      end else if (clk_en_in && byte_end && ack_want) begin
         if (is_cmd) begin
            frame_reg.cmd <= shift_reg;
         end
         if (byte_idx_reg == `SCW_IDX_LO) begin
            frame_reg.lo <= shift_reg;
         end
         if (byte_idx_reg == `SCW_IDX_HI) begin
            frame_reg.hi <= shift_reg;
         end
      end
   end

   // SDA changes wait out the hold time after each SCL fall
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hold_cnt_reg <= 6'h00;
         hold_val_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (start_det || comm_end) begin
            hold_cnt_reg <= 6'h00;
         end else if (byte_end) begin
            hold_cnt_reg <= HOLD_CYC;
            hold_val_reg <= ack_want;
         end else if (ack_end) begin
            hold_cnt_reg <= HOLD_CYC;
            hold_val_reg <= 1'b0;
         end else if (hold_cnt_reg != 6'h00) begin
            hold_cnt_reg <= hold_cnt_reg - 6'h01;
         end
      end
   end

   // Drive only for acknowledge; released on any link reset
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sda_oe_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (start_det || comm_end) begin
            sda_oe_reg <= 1'b0;
         end else if (hold_cnt_reg == 6'h01) begin
            sda_oe_reg <= hold_val_reg;
         end
      end
   end

   // Timeout counter restarts on every SCL edge
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         to_cnt_reg <= '0;
      end else if (clk_en_in) begin
         if (!in_frame || scl_edge || start_det) begin
            to_cnt_reg <= '0;
         end else if (!to_hit) begin
            to_cnt_reg <= to_cnt_reg + TO_W'(1);
         end
      end
   end

   // Store time; address byte is refused until it runs out
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_cnt_reg <= '0;
      end else if (clk_en_in) begin
         if (wr_emis || wr_addr) begin
            busy_cnt_reg <= WR_W'(WRITE_CYC);
         end else if (busy_cnt_reg != '0) begin
            busy_cnt_reg <= busy_cnt_reg - WR_W'(1);
         end
      end
   end

   // Cells load once from the store after release of reset
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cells_reg <= {`SCW_EMIS_RST, `SCW_ADDR_RST};
         active_addr_reg <= 7'(`SCW_ADDR_RST);
         loaded_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (!loaded_reg) begin
            cells_reg <= nv_cells_in;
            active_addr_reg <= nv_cells_in.addr[6:0];
            loaded_reg <= 1'b1;
         end else begin
            if (wr_emis) begin
               cells_reg.emis <= word;
            end
            if (wr_addr) begin
               cells_reg.addr <= word;
            end
         end
      end
   end

   // One-cycle strobe tells the store to keep the cells
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         strobe_reg <= 1'b0;
      end else if (clk_en_in) begin
         strobe_reg <= wr_emis | wr_addr;
      end
   end

   // Outputs; open drain, so the data level is always low
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe_reg;
   assign cells_out = cells_reg;
   assign store_strobe_out = strobe_reg;
   assign busy_out = (busy_cnt_reg != '0);
   assign active_addr_out = active_addr_reg;
endmodule

// file: testbench/scw_target_properties.sv
module scw_target_properties #(
   parameter int unsigned LOW_TO_CYC = 2000,
   parameter int unsigned HIGH_TO_CYC = 800,
   parameter int unsigned WRITE_CYC = 300
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // Watched ports
   input wire logic scl_in,
   input logic sda_out,
   input logic sda_oe_out,
   input scw_pkg::scw_cells_t cells_out,
   input logic store_strobe_out,
   input logic busy_out,
   input logic [6:0] active_addr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import scw_pkg::*;
   logic [31:0] low_cnt_reg, high_cnt_reg, busy_cnt_reg;
   // Run lengths; SCL is async but only coarse counts are needed
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         low_cnt_reg <= 32'h0;
         high_cnt_reg <= 32'h0;
         busy_cnt_reg <= 32'h0;
      end else begin
         low_cnt_reg <= scl_in ? 32'h0 : low_cnt_reg + 32'h1;
         high_cnt_reg <= scl_in ? high_cnt_reg + 32'h1 : 32'h0;
         busy_cnt_reg <= busy_out ? busy_cnt_reg + 32'h1 : 32'h0;
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   a_ack_pulls_low: assert property (
      sda_oe_out |-> sda_out == 1'b0) else $error("sda driven high");
   a_ack_window: assert property (
      $rose(sda_oe_out) |-> !scl_in && low_cnt_reg inside {[36:313]})
      else $error("ack outside low window");
   a_low_timeout: assert property (
      low_cnt_reg > LOW_TO_CYC + 8 |-> !sda_oe_out)
      else $error("sda held past low timeout");
   a_high_timeout: assert property (
      high_cnt_reg > HIGH_TO_CYC + 8 |-> !sda_oe_out)
      else $error("sda held past high timeout");
   a_strobe_single: assert property (
      store_strobe_out |=> !store_strobe_out) else $error("long strobe");
   a_busy_on_store: assert property (
      store_strobe_out |-> ##[0:1] busy_out) else $error("no busy");
   a_busy_length: assert property (
      $fell(busy_out) |-> busy_cnt_reg == WRITE_CYC)
      else $error("busy length wrong");
   a_cells_frozen: assert property (
      busy_out && $past(busy_out) |-> $stable(cells_out))
      else $error("cell changed while busy");
   a_addr_fixed: assert property (
      busy_out |-> $stable(active_addr_out)) else $error("address moved");
endmodule
bind scw_target scw_target_properties #(.LOW_TO_CYC(LOW_TO_CYC),
   .HIGH_TO_CYC(HIGH_TO_CYC), .WRITE_CYC(WRITE_CYC)) u_props (
   .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .cells_out(cells_out),
   .store_strobe_out(store_strobe_out), .busy_out(busy_out),
   .active_addr_out(active_addr_out));

// file: testbench/scw_host_model.sv
module scw_host_model (
   // Timing reference
   input wire logic clk_in,
   // Two-wire link
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Half bit and SDA hold in cycles; rate scaled like the timeouts
   localparam int HALF = 50;
   localparam int HOLD = 45;
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic hold_for(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // One SCL pulse
   task automatic put_bit(input logic v, output logic s);
      hold_for(HOLD);
      sda_low_out = ~v;
      hold_for(HALF - HOLD);
      scl_out = 1'b1;
      s = sda_in;
      hold_for(HALF);
      scl_out = 1'b0;
   endtask
   // Write Word; a stall holds SCL inside the first acknowledge
   task automatic frame(input logic [7:0] b [5], input logic stall_hi,
         input int stall_n, output logic [4:0] ack);
      logic s;
      ack = 5'h00;
      sda_low_out = 1'b1;
      hold_for(HALF);
      scl_out = 1'b0;
      for (int i = 0; i < 5; i++) begin
         for (int k = 7; k >= 0; k--) put_bit(b[i][k], s);
         if (stall_n > 0) begin
            hold_for(HOLD);
            sda_low_out = 1'b0;
            scl_out = stall_hi;
            hold_for(stall_n);
            ack[0] = ~sda_in;
            scl_out = 1'b0;
            break;
         end
         put_bit(1'b1, s);
         ack[i] = ~s;
      end
      // Stop, then bus free time
      hold_for(HOLD);
      sda_low_out = 1'b1;
      hold_for(HALF - HOLD);
      scl_out = 1'b1;
      hold_for(HALF);
      sda_low_out = 1'b0;
      hold_for(HALF);
   endtask
endmodule

// file: testbench/scw_target_test.sv
module scw_target_test;
   timeunit 1ns;
   timeprecision 1ps;
   import scw_pkg::*;
   localparam int unsigned LOW_TO = 2000;
   localparam int unsigned HIGH_TO = 800;
   localparam int unsigned WR = 1500;
   logic sys_clk_in = 1'b0;
   logic rst_b_in, clk_en_in, scl, sda, host_low;
   logic sda_out, sda_oe_out, store_strobe_out, busy_out;
   logic [6:0] active_addr_out;
   logic [4:0] acks;
   logic [15:0] emis;
   scw_cells_t nv_cells_in, cells_out, exp_cells;
   scw_cells_t exp_q[$];
   int failures = 0;
   int n_compared = 0;
   int seed = 19;
   int cycles = 0;
   // Open drain SDA with pull-up
   always #4 sys_clk_in = ~sys_clk_in;
   assign sda = ~host_low & (sda_oe_out ? sda_out : 1'b1);
   scw_target #(.LOW_TO_CYC(LOW_TO), .HIGH_TO_CYC(HIGH_TO),
      .WRITE_CYC(WR)) u_dut (.sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in), .clk_en_in(clk_en_in), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .nv_cells_in(nv_cells_in), .cells_out(cells_out),
      .store_strobe_out(store_strobe_out), .busy_out(busy_out),
      .active_addr_out(active_addr_out));
   scw_host_model u_host (.clk_in(sys_clk_in), .sda_in(sda),
      .scl_out(scl), .sda_low_out(host_low));
   task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // CRC-8, poly 0x07, MSB first
   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   // One frame and its acknowledges; waits out the store time
   task automatic send(input logic [7:0] c, lo, hi, input logic [4:0] ea,
         input logic wt = 1'b1, input logic bad = 1'b0,
         input logic [7:0] a = 8'h74, input int st = 0,
         input logic lvl = 1'b0);
      logic [7:0] b [5];
      b = '{a, c, lo, hi, crc8({a, c, lo, hi}) ^ {7'h0, bad}};
      u_host.frame(b, lvl, st, acks);
      cmp_val({27'h0, ea}, {27'h0, acks});
      for (int i = 0; i < 4000 && wt && busy_out !== 1'b0; i++)
         @(negedge sys_clk_in);
      // A store time that never ends counts as a mismatch
      if (wt)
         cmp_val(32'h0, {31'h0, busy_out});
   endtask
   // Each store is paired with the oldest expectation
   always @(negedge sys_clk_in)
      if (store_strobe_out === 1'b1) begin
         exp_cells = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
         cmp_val(exp_cells, cells_out);
      end
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 90000) begin
         failures++;
         report_and_stop;
      end
   end
   initial begin
      rst_b_in = 1'b0;
      clk_en_in = 1'b0;
      emis = 16'($random(seed)) | 16'h2000;
      nv_cells_in = {emis, 16'h003a};
      repeat (10) @(negedge sys_clk_in);
      cmp_val({16'hf850, 16'h003a}, cells_out);
      rst_b_in = 1'b1;
      clk_en_in = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      cmp_val({emis, 16'h003a}, cells_out);
      // Erase, then a frame inside the store time is refused
      exp_q.push_back({16'h0000, 16'h003a});
      send(8'h24, 8'h00, 8'h00, 5'h1f, 1'b0);
      send(8'h24, 8'h00, 8'h00, 5'h00);
      exp_q.push_back({16'hffff, 16'h003a});
      send(8'h24, 8'hff, 8'hff, 5'h1f);
      // SCL stalls low and high inside an acknowledge
      send(8'h24, 8'h00, 8'h00, 5'h00, 1'b1, 1'b0, 8'h74, LOW_TO + 50);
      send(8'h24, 8'h00, 8'h00, 5'h00, 1'b1, 1'b0, 8'h74, HIGH_TO + 50,
         1'b1);
      emis = 16'($random(seed)) | 16'h2000;
      exp_q.push_back({16'h0000, 16'h003a});
      send(8'h24, 8'h00, 8'h00, 5'h1f);
      exp_q.push_back({emis, 16'h003a});
      send(8'h24, emis[7:0], emis[15:8], 5'h1f);
      exp_q.push_back({emis, 16'h0000});
      send(8'h2e, 8'h00, 8'h00, 5'h1f);
      exp_q.push_back({emis, 16'h004c});
      send(8'h2e, 8'h4c, 8'h00, 5'h1f);
      cmp_val(32'h3a, {25'h0, active_addr_out});
      // Bad PEC and a foreign address change nothing
      send(8'h24, 8'h00, 8'h00, 5'h0f, 1'b1, 1'b1);
      send(8'h24, 8'h00, 8'h00, 5'h00, 1'b1, 1'b0, 8'h76);
      // Restart picks up the stored address
      // Restart with the enable low: no load until it rises
      rst_b_in = 1'b0;
      clk_en_in = 1'b0;
      nv_cells_in = {emis, 16'h004c};
      repeat (2) @(negedge sys_clk_in);
      rst_b_in = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      cmp_val(32'h3a, {25'h0, active_addr_out});
      clk_en_in = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      cmp_val(32'h4c, {25'h0, active_addr_out});
      exp_q.push_back({16'h0000, 16'h004c});
      send(8'h24, 8'h00, 8'h00, 5'h1f, 1'b1, 1'b0, 8'h98);
      // General address is taken; code below 0.1 is not stored
      send(8'h24, 8'h97, 8'h19, 5'h1f, 1'b1, 1'b0, 8'h00);
      // Unknown command code is refused at its own byte
      send(8'h06, 8'h00, 8'h00, 5'h01, 1'b1, 1'b0, 8'h98);
      cmp_val({16'h0000, 16'h004c}, cells_out);
      cmp_val(32'h0, exp_q.size());
      report_and_stop;
   end
endmodule
